//--- logic/ccg_clock_control.sv
`timescale 1ns/10ps
`default_nettype none

// Switches between clock levels only while both are low
module ccg_glitch_free_mux (
  input  wire logic       pclk,     // Block clock
  input  wire logic       presetn,  // Async reset, active low
  input  wire logic [3:0] src,      // Synchronised source levels
  input  wire logic [1:0] want,     // Requested source
  output logic            out,      // Selected level, registered
  output logic [1:0]      cur       // Source now applied
);
  // Applied selection moves only at a common low phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= ccg_pkg::SEL_RST_ZERO;
    end else if (want != cur && !out && !src[cur] && !src[want]) begin
      cur <= want;
    end
  end

  // Output follows the applied source one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out <= 1'b0;
    end else begin
      out <= src[cur];
    end
  end

  // Two quiet cycles around a change
  sequence low_around_switch;
    !out && !$past(out);
  endsequence
  AST_GFM_SWITCH_LOW: assert property (
    @(posedge pclk) disable iff (!presetn) $changed(cur) |-> low_around_switch)
    else $error("Clock source switched while output high");
  AST_GFM_FOLLOW: assert property (
    @(posedge pclk) disable iff (!presetn)
    $stable(cur) |=> out == $past(src[cur]))
    else $error("Mux output does not follow applied source");
endmodule : ccg_glitch_free_mux

// Phase accumulator giving tick rate times step over mod
module ccg_frac_div (
  input  wire logic       pclk,     // Block clock
  input  wire logic       presetn,  // Async reset, active low
  input  wire logic       tick,     // One pulse per 48 MHz rising edge
  input  wire logic       en,       // Run when high
  input  wire logic [6:0] step,     // Step value
  input  wire logic [7:0] mod,      // Mod value
  output logic            clk_out   // Divided clock, registered
);
  logic [7:0] acc;       // Phase accumulator
  logic [8:0] sum;       // Accumulator plus step
  logic [7:0] next_acc;  // Wrapped accumulator

  // Wrap at mod; half of each period is high
  always_comb begin
    sum      = {1'b0, acc} + {2'h0, step};
    next_acc = sum[7:0];
    if (sum >= {1'b0, mod}) begin
      next_acc = 8'(sum - {1'b0, mod});
    end
  end

  // Stopped divider parks low so the restart is clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc     <= 8'h00;
      clk_out <= 1'b0;
    end else if (!en) begin
      acc     <= 8'h00;
      clk_out <= 1'b0;
    end else if (tick) begin
      acc     <= next_acc;
      clk_out <= (next_acc >= (mod >> 1));
    end
  end

  AST_FRAC_STOPPED: assert property (
    @(posedge pclk) disable iff (!presetn) !en |=> (!clk_out && acc == 8'h00))
    else $error("Fractional clock runs while disabled");
  AST_FRAC_STEP: assert property (
    @(posedge pclk) disable iff (!presetn)
    (en && tick && $stable(mod) && mod >= {step, 1'b0} && acc < mod)
      |=> acc == 8'((9'($past(acc)) + 9'($past(step))) % 9'($past(mod))))
    else $error("Fractional accumulator did not advance by step");
endmodule : ccg_frac_div

// Clock selection, division and module gating behind APB
module ccg_clock_control (
  input  wire logic            pclk,     // APB clock, 125 MHz
  input  wire logic            presetn,  // Async reset, active low
  input  wire logic            psel,     // APB select
  input  wire logic            penable,  // APB access phase
  input  wire logic            pwrite,   // APB direction
  input  wire logic [9:0]      paddr,    // APB byte address
  input  wire logic [31:0]     pwdata,   // APB write data
  output logic      [31:0]     prdata,   // APB read data, registered
  output logic                 pready,   // APB ready
  output logic                 pslverr,  // APB error on unmapped access
  input  wire ccg_pkg::ccg_src_t src,    // Raw oscillator clocks
  output ccg_pkg::ccg_clk_t    clk_out   // Produced clock levels
);
  ccg_pkg::ccg_regs_t regs;       // Software registers
  ccg_pkg::ccg_src_t  sync1;      // First synchroniser stage
  ccg_pkg::ccg_src_t  sync2;      // Second synchroniser stage
  ccg_pkg::ccg_src_t  prev;       // Last cycle, for edge finding
  logic               x48_rise;   // Doubled clock rising edge
  logic [1:0]         tt_edge;    // Edges feeding two-thirds dividers
  logic [1:0]         tt_lvl;     // Two-thirds outputs: 32 MHz, timer
  logic               fast_lvl;   // Fast source level
  logic               fast_prev;  // Fast level last cycle
  logic [1:0]         fast_cur;   // Applied fast selection
  logic [4:0]         div_n;      // Effective divide ratio
  logic [4:0]         div_cnt;    // Divider count
  logic               div_lvl;    // Divided clock level
  logic               sys_lvl;    // System clock level
  logic [1:0]         sys_cur;    // Applied system selection
  logic               i2s_lvl;    // Audio serial divider out
  logic               mic_div;    // Microphone divider out
  logic               lf_lvl;     // Selected 32 kHz level
  logic [1:0]         lf_cur;     // Applied 32 kHz selection
  logic               pin_lvl;    // Microphone pin level
  logic [1:0]         pin_cur;    // Applied pin selection
  logic [23:0]        gate_en;    // Gate requests, reserved masked
  logic [23:0]        gate_q;     // Gate enables held at low phase
  logic [23:0]        gated;      // Gated clock levels
  logic [7:0]         rd_idx;     // Register index from address
  logic               hit;        // Address maps to a register
  logic [7:0]         rd_val;     // Selected read value
  logic [7:0]         status;     // Applied selections

  // Sources come from other domains: two flops before any use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end else begin
      sync1 <= src;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  assign x48_rise = sync2.x48 & ~prev.x48;
  assign tt_edge  = {sync2.x24 ^ prev.x24, sync2.x48 ^ prev.x48};

  // Fast source: index 0 doubled, 1 rc, 2 and 3 crystal
  // two-register selector
  ccg_glitch_free_mux u_fast_mux (
    .pclk    (pclk),
    .presetn (presetn),
    .src     ({sync2.x24, sync2.x24, sync2.rc24, sync2.x48}),
    .want    ({regs.fast_sel[ccg_pkg::FAST_SEL_BIT], regs.sys_sel[ccg_pkg::SYS_FAST_BIT]}),
    .out     (fast_lvl),
    .cur     (fast_cur)
  );

  // Two-thirds dividers count both edges, one third duty
  // 32 MHz from doubled clock; timer from crystal
  for (genvar g = 0; g < 2; g++) begin : g_two_thirds
    logic [1:0] ph;  // Half-period phase
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ph        <= 2'h0;
        tt_lvl[g] <= 1'b0;
      end else if (tt_edge[g]) begin
        ph        <= (ph == ccg_pkg::TWO_THIRDS_LAST) ? 2'h0 : 2'(ph + 2'h1);
        tt_lvl[g] <= (ph == ccg_pkg::TWO_THIRDS_LAST);
      end
    end
    AST_TT_PHASE: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(tt_lvl[g]) |-> (ph == 2'h0 && $past(tt_edge[g])))
      else $error("Two-thirds divider high outside phase zero");
  end

  // Ratios below two would stall the divider
  // guard on divider value
  assign div_n = (regs.sys_sel[ccg_pkg::SYS_DIV_MSB:0] < ccg_pkg::DIV_MIN)
               ? ccg_pkg::DIV_MIN : regs.sys_sel[ccg_pkg::SYS_DIV_MSB:0];

  // Integer divider counts fast rising edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_prev <= 1'b0;
      div_cnt   <= 5'h00;
      div_lvl   <= 1'b0;
    end else begin
      fast_prev <= fast_lvl;
      // one output period per div_n fast periods
      if (fast_lvl && !fast_prev) begin
        div_cnt <= (div_cnt >= 5'(div_n - 5'h01)) ? 5'h00 : 5'(div_cnt + 5'h01);
        div_lvl <= (div_cnt >= 5'(div_n - 5'h01));
      end
    end
  end

  AST_DIV_WRAP: assert property (
    @(posedge pclk) disable iff (!presetn)
    (fast_lvl && !fast_prev && $stable(div_n) && div_cnt == 5'(div_n - 5'h01))
      |=> (div_cnt == 5'h00 && div_lvl))
    else $error("System clock divider failed to wrap");

  // System clock: 0 rc, 1 fast, 2 divided, 3 two-thirds
  // two-bit source select
  ccg_glitch_free_mux u_sys_mux (
    .pclk    (pclk),
    .presetn (presetn),
    .src     ({tt_lvl[0], div_lvl, fast_lvl, sync2.rc24}),
    .want    (regs.sys_sel[ccg_pkg::SYS_SRC_MSB:ccg_pkg::SYS_SRC_LSB]),
    .out     (sys_lvl),
    .cur     (sys_cur)
  );

  // audio serial enable bit; step and mod
  ccg_frac_div u_i2s_div (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (x48_rise),
    .en      (regs.i2s_step[ccg_pkg::FRAC_EN_BIT]),
    .step    (regs.i2s_step[ccg_pkg::FRAC_STEP_MSB:0]),
    .mod     (regs.i2s_mod),
    .clk_out (i2s_lvl)
  );

  // microphone enable bit; step and mod
  ccg_frac_div u_mic_div (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (x48_rise),
    .en      (regs.mic_step[ccg_pkg::FRAC_EN_BIT]),
    .step    (regs.mic_step[ccg_pkg::FRAC_STEP_MSB:0]),
    .mod     (regs.mic_mod),
    .clk_out (mic_div)
  );

  // 32 kHz source: 0 rc, 1 crystal
  // low-frequency source bit
  ccg_glitch_free_mux u_lf_mux (
    .pclk    (pclk),
    .presetn (presetn),
    .src     ({2'b00, sync2.x32k, sync2.rc32k}),
    .want    ({1'b0, regs.lf_sel[ccg_pkg::LF_SRC_BIT]}),
    .out     (lf_lvl),
    .cur     (lf_cur)
  );

  // Microphone pin: 0 divider, 1 the 32 kHz clock
  // pin source bit
  ccg_glitch_free_mux u_pin_mux (
    .pclk    (pclk),
    .presetn (presetn),
    .src     ({2'b00, lf_lvl, mic_div}),
    .want    ({1'b0, regs.lf_sel[ccg_pkg::LF_MIC_BIT]}),
    .out     (pin_lvl),
    .cur     (pin_cur)
  );

  AST_PIN_SOURCE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pin_cur == 2'h1 && $stable(pin_cur)) |=> pin_lvl == $past(lf_lvl))
    else $error("Microphone pin not following the 32 kHz clock");

  // Reserved gate bits are stored as zero
  // gate a; gate b; gate c
  assign gate_en = {regs.gate_c & ccg_pkg::GATE_C_MASK,
                    regs.gate_b & ccg_pkg::GATE_B_MASK,
                    regs.gate_a & ccg_pkg::GATE_A_MASK};

  // Gates change only while their clock is low, so no runt pulse
  for (genvar i = 0; i < ccg_pkg::NUM_GATES; i++) begin : g_gate
    logic base;  // Clock feeding this gate
    assign base = (i == ccg_pkg::TIMER_GATE) ? tt_lvl[1] : sys_lvl;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        gate_q[i] <= 1'b0;
        gated[i]  <= 1'b0;
      end else begin
        if (!base) begin
          gate_q[i] <= gate_en[i];
        end
        gated[i] <= base & gate_q[i];
      end
    end
  end

  AST_GATE_RESERVED: assert property (
    @(posedge pclk) disable iff (!presetn)
    (gated & ~{ccg_pkg::GATE_C_MASK, ccg_pkg::GATE_B_MASK, ccg_pkg::GATE_A_MASK}) == 24'h0)
    else $error("Reserved gate produced a clock");
  AST_GATE_OFF: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!gate_en[0] && !sys_lvl) |=> ##1 !gated[0])
    else $error("Disabled module clock still running");

  assign clk_out = '{sys: sys_lvl, fast: fast_lvl, timer16: tt_lvl[1], i2s: i2s_lvl,
                     mic_pin: pin_lvl, lf32k: lf_lvl, gated: gated};

  // Applied selections, for software to see a switch has landed
  assign status = {2'b00, pin_cur[0], lf_cur[0], fast_cur, sys_cur};

  // Address decode; zero wait states, low bits of address ignored
  assign rd_idx = paddr[9:2];
  always_comb begin
    hit    = 1'b1;
    rd_val = 8'h00;
    case (rd_idx)
      ccg_pkg::IDX_GATE_A:   rd_val = regs.gate_a;
      ccg_pkg::IDX_GATE_B:   rd_val = regs.gate_b;
      ccg_pkg::IDX_GATE_C:   rd_val = regs.gate_c;
      ccg_pkg::IDX_SYS_SEL:  rd_val = regs.sys_sel;
      ccg_pkg::IDX_I2S_STEP: rd_val = regs.i2s_step;
      ccg_pkg::IDX_I2S_MOD:  rd_val = regs.i2s_mod;
      ccg_pkg::IDX_MIC_STEP: rd_val = regs.mic_step;
      ccg_pkg::IDX_MIC_MOD:  rd_val = regs.mic_mod;
      ccg_pkg::IDX_FAST_SEL: rd_val = regs.fast_sel;
      ccg_pkg::IDX_LF_SEL:   rd_val = regs.lf_sel;
      ccg_pkg::IDX_STATUS:   rd_val = status;
      default:               hit    = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // Read data captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rd_val};
    end
  end

  // Writes land at the access edge; status and unmapped ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regs <= '{gate_a: ccg_pkg::RST_GATE_A, gate_b: ccg_pkg::RST_GATE_B,
                gate_c: ccg_pkg::RST_GATE_C, sys_sel: ccg_pkg::RST_SYS_SEL,
                i2s_step: ccg_pkg::RST_I2S_STEP, i2s_mod: ccg_pkg::RST_I2S_MOD,
                mic_step: ccg_pkg::RST_MIC_STEP, mic_mod: ccg_pkg::RST_MIC_MOD,
                fast_sel: ccg_pkg::RST_FAST_SEL, lf_sel: ccg_pkg::RST_LF_SEL};
    end else if (psel && penable && pwrite) begin
      case (rd_idx)
        ccg_pkg::IDX_GATE_A:   regs.gate_a   <= pwdata[7:0] & ccg_pkg::GATE_A_MASK;
        ccg_pkg::IDX_GATE_B:   regs.gate_b   <= pwdata[7:0] & ccg_pkg::GATE_B_MASK;
        ccg_pkg::IDX_GATE_C:   regs.gate_c   <= pwdata[7:0] & ccg_pkg::GATE_C_MASK;
        ccg_pkg::IDX_SYS_SEL:  regs.sys_sel  <= pwdata[7:0];
        ccg_pkg::IDX_I2S_STEP: regs.i2s_step <= pwdata[7:0];
        ccg_pkg::IDX_I2S_MOD:  regs.i2s_mod  <= pwdata[7:0];
        ccg_pkg::IDX_MIC_STEP: regs.mic_step <= pwdata[7:0];
        ccg_pkg::IDX_MIC_MOD:  regs.mic_mod  <= pwdata[7:0];
        ccg_pkg::IDX_FAST_SEL: regs.fast_sel <= pwdata[7:0];
        ccg_pkg::IDX_LF_SEL:   regs.lf_sel   <= pwdata[7:0];
        default:               regs          <= regs;
      endcase
    end
  end

  AST_GATE_B_RSVD: assert property (
    @(posedge pclk) disable iff (!presetn)
    (regs.gate_b & ~ccg_pkg::GATE_B_MASK) == 8'h00)
    else $error("Reserved bits of gate b set");
endmodule : ccg_clock_control
`default_nettype wire

//--- logic/ccg_pkg.sv
`default_nettype none
// Shared constants and carriers for the clock control block
package ccg_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_GATE_A   = 8'h63;
  localparam logic [7:0] IDX_GATE_B   = 8'h64;
  localparam logic [7:0] IDX_GATE_C   = 8'h65;
  localparam logic [7:0] IDX_SYS_SEL  = 8'h66;
  localparam logic [7:0] IDX_I2S_STEP = 8'h67;
  localparam logic [7:0] IDX_I2S_MOD  = 8'h68;
  localparam logic [7:0] IDX_MIC_STEP = 8'h6c;
  localparam logic [7:0] IDX_MIC_MOD  = 8'h6d;
  localparam logic [7:0] IDX_FAST_SEL = 8'h70;
  localparam logic [7:0] IDX_LF_SEL   = 8'h73;
  localparam logic [7:0] IDX_STATUS   = 8'h74;
  // Reset values
  localparam logic [7:0] RST_GATE_A   = 8'h83;
  localparam logic [7:0] RST_GATE_B   = 8'h00;
  localparam logic [7:0] RST_GATE_C   = 8'h30;
  localparam logic [7:0] RST_SYS_SEL  = 8'h06;
  localparam logic [7:0] RST_I2S_STEP = 8'h00;
  localparam logic [7:0] RST_I2S_MOD  = 8'h02;
  localparam logic [7:0] RST_MIC_STEP = 8'h01;
  localparam logic [7:0] RST_MIC_MOD  = 8'h02;
  localparam logic [7:0] RST_FAST_SEL = 8'h00;
  localparam logic [7:0] RST_LF_SEL   = 8'h04;
  // Writable bits of the gate registers; reserved bits hold zero
  localparam logic [7:0] GATE_A_MASK  = 8'hbf;
  localparam logic [7:0] GATE_B_MASK  = 8'h1f;
  localparam logic [7:0] GATE_C_MASK  = 8'h37;
  // Field positions
  localparam int SYS_DIV_MSB   = 4;
  localparam int SYS_SRC_MSB   = 6;
  localparam int SYS_SRC_LSB   = 5;
  localparam int SYS_FAST_BIT  = 7;
  localparam int FAST_SEL_BIT  = 0;
  localparam int LF_SRC_BIT    = 0;
  localparam int LF_MIC_BIT    = 1;
  localparam int FRAC_EN_BIT   = 7;
  localparam int FRAC_STEP_MSB = 6;
  localparam int NUM_GATES     = 24;
  localparam int TIMER_GATE    = 9;  // Gate b, bit 1
  // Smallest usable integer divide ratio
  localparam logic [4:0] DIV_MIN = 5'h02;
  // Two-thirds divider: three source half periods per output period
  localparam logic [1:0] TWO_THIRDS_LAST = 2'h2;
  // Mux selections applied at reset
  localparam logic [1:0] SEL_RST_ZERO = 2'h0;

  // Raw source clocks arriving from the oscillators
  typedef struct packed {
    logic rc24;   // rc_osc_24m
    logic x24;    // crystal_24m_clock
    logic x48;    // Doubled crystal clock
    logic rc32k;  // rc_osc_32k
    logic x32k;   // crystal_32k_clock
  } ccg_src_t;

  // Clock levels produced by the block
  typedef struct packed {
    logic                  sys;      // System clock
    logic                  fast;     // fast_source_clock
    logic                  timer16;  // System timer clock
    logic                  i2s;      // Audio serial clock
    logic                  mic_pin;  // digital_microphone clock pin
    logic                  lf32k;    // Selected 32 kHz clock
    logic [NUM_GATES-1:0]  gated;    // Per-module gated clocks
  } ccg_clk_t;

  // Software registers
  typedef struct packed {
    logic [7:0] gate_a;
    logic [7:0] gate_b;
    logic [7:0] gate_c;
    logic [7:0] sys_sel;
    logic [7:0] i2s_step;
    logic [7:0] i2s_mod;
    logic [7:0] mic_step;
    logic [7:0] mic_mod;
    logic [7:0] fast_sel;
    logic [7:0] lf_sel;
  } ccg_regs_t;
endpackage : ccg_pkg
`default_nettype wire

//--- verification/test_ccg_clock_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_ccg_clock_control;
  localparam int WIN = 2000;  // Measurement window, pclk cycles
  localparam int TOL = 3;     // Slack for 8 ns sampling jitter
  // One write and the frequency it should produce
  typedef struct {
    logic [7:0] idx;  // Register index
    logic [7:0] val;  // Value written
    int         sel;  // Output watched
    int         khz;  // Expected frequency
  } ccg_row_t;
  logic                pclk;             // Bus clock
  logic                presetn;          // Reset, active low
  logic                psel;             // APB select
  logic                penable;          // APB access phase
  logic                pwrite;           // APB direction
  logic [9:0]          paddr;            // APB byte address
  logic [31:0]         pwdata;           // APB write data
  logic [31:0]         prdata;           // APB read data
  logic                pready;           // APB ready
  logic                pslverr;          // APB error
  logic [31:0]         rd;               // Last read data
  logic                err;              // Last error flag
  ccg_pkg::ccg_src_t   src;              // Oscillator levels
  ccg_pkg::ccg_clk_t   clk_out;          // Produced clocks
  int                  failures;         // Mismatch count
  int                  samples_checked;  // Comparison count
  int                  n;                // Measured edges
  // Index order shared by reset and readback loops; status last
  logic [7:0] ridx [11] = '{8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h6c, 8'h6d, 8'h70,
                            8'h73, 8'h74};
  logic [7:0] rval [11] = '{8'h83, 8'h00, 8'h30, 8'h06, 8'h00, 8'h02, 8'h01, 8'h02, 8'h00,
                            8'h04, 8'h00};
  // Readback after writing all ones; reserved gate bits stay zero
  logic [7:0] wval [10] = '{8'hbf, 8'h1f, 8'h37, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
                            8'hff};
  // Sel: 0 sys 1 fast 2 timer 3 audio 4 mic pin 5 gate a0 6 gate b1 7 lf 8 gate c0
  ccg_row_t rows [29] = '{
    '{8'h66, 8'h06, 0, 25000}, '{8'h70, 8'h00, 1, 48000},
    '{8'h66, 8'h26, 0, 48000}, '{8'h66, 8'h44, 0, 12000},
    '{8'h66, 8'h42, 0, 24000}, '{8'h66, 8'h43, 0, 16000},
    '{8'h66, 8'h62, 0, 32000}, '{8'h66, 8'ha2, 1, 25000},
    '{8'h70, 8'h01, 1, 24000}, '{8'h66, 8'h26, 0, 24000},
    '{8'h63, 8'h82, 5, 0},     '{8'h63, 8'h83, 5, 24000},
    '{8'h64, 8'h02, 6, 16000}, '{8'h64, 8'h00, 6, 0},
    '{8'h64, 8'h00, 2, 16000}, '{8'h67, 8'h01, 3, 0},
    '{8'h68, 8'h04, 3, 0},     '{8'h67, 8'h81, 3, 12000},
    '{8'h67, 8'h82, 3, 24000}, '{8'h6c, 8'h01, 4, 250},
    '{8'h73, 8'h04, 4, 0},     '{8'h6d, 8'h08, 4, 0},
    '{8'h6c, 8'h81, 4, 6000},  '{8'h73, 8'h06, 4, 500},
    '{8'h73, 8'h07, 7, 250},   '{8'h73, 8'h05, 4, 6000},
    '{8'h73, 8'h04, 7, 500},   '{8'h65, 8'h36, 8, 0},
    '{8'h65, 8'h37, 8, 24000}};

  // Clock and oscillators; 32 kHz ones sped up to keep the run short
  always #4 pclk = ~pclk;
  always #20 src.rc24 = ~src.rc24;
  always #20.833 src.x24 = ~src.x24;
  always #10.417 src.x48 = ~src.x48;
  always #1000 src.rc32k = ~src.rc32k;
  always #2000 src.x32k = ~src.x32k;

  ccg_clock_control ccg_clock_control_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .src     (src),
    .clk_out (clk_out)
  );

  // Verdict and end of run
  task automatic conclude();
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  // One APB transfer; waits on pready with a bound
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      failures++;
      conclude();
    end
  endtask : apb

  // Value comparison
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  // Edge count comparison with sampling slack
  task automatic check_cnt(input string what, input int exp, input int got);
    samples_checked++;
    if (got < exp - TOL || got > exp + TOL) begin
      failures++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_cnt

  // Level of the watched output
  function automatic logic pick(input int s);
    case (s)
      0: pick = clk_out.sys;
      1: pick = clk_out.fast;
      2: pick = clk_out.timer16;
      3: pick = clk_out.i2s;
      4: pick = clk_out.mic_pin;
      5: pick = clk_out.gated[0];
      6: pick = clk_out.gated[9];
      8: pick = clk_out.gated[16];
      default: pick = clk_out.lf32k;
    endcase
  endfunction : pick

  // Rising edges seen over the window, sampled mid-cycle
  task automatic measure(input int s, output int cnt);
    logic prev;
    cnt  = 0;
    prev = pick(s);
    repeat (WIN) begin
      @(negedge pclk);
      if (pick(s) === 1'b1 && prev !== 1'b1) begin
        cnt++;
      end
      prev = pick(s);
    end
  endtask : measure

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    src = '0;
    failures = 0;
    samples_checked = 0;
    repeat (6) @(posedge pclk);
    check_val("clocks in reset", 32'h0, 32'(clk_out));
    presetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      apb(1'b0, ridx[i], 8'h00);
      check_val("reset value", {24'h0, rval[i]}, rd);
    end
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, ridx[i], 8'hff);
      apb(1'b0, ridx[i], 8'h00);
      check_val("readback", {24'h0, wval[i]}, rd);
    end
    // Rows: write, let the glitch-free switch settle, then count
    foreach (rows[i]) begin
      apb(1'b1, rows[i].idx, rows[i].val);
      repeat (200) @(posedge pclk);
      measure(rows[i].sel, n);
      check_cnt("edge count", rows[i].khz * WIN * 8 / 1000000, n);
    end
    apb(1'b1, 8'h69, 8'h5a);
    check_val("unmapped write error", 32'h1, {31'h0, err});
    apb(1'b0, 8'h69, 8'h00);
    check_val("unmapped read data", 32'h0, rd);
    apb(1'b1, ccg_pkg::IDX_STATUS, 8'hff);
    check_val("status write error", 32'h0, {31'h0, err});
    // Mid-run reset restores register defaults
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ccg_pkg::IDX_GATE_A, 8'h00);
    check_val("gate a after reset", 32'h83, rd);
    apb(1'b0, ccg_pkg::IDX_SYS_SEL, 8'h00);
    check_val("select after reset", 32'h06, rd);
    conclude();
  end
endmodule : test_ccg_clock_control
`default_nettype wire
